// >>> design/gpf_pkg.sv
// package: constants, field layout and types of the pin function block
// assumes one clock domain and a documented register port (no public bus)
// How it works
// [RULE1] filter bit 15 enables input glitch filter
// [RULE2] output bit 13 lets device drive pin
// [RULE3] source field 12-9 picks mirrored status bit
// [RULE4] channel mask 8-5 selects per-channel actions
// [RULE5] input function field 4-1 selects action
// [RULE6] 0000: fall sleeps device, rise wakes
// [RULE7] 0010: falling edge triggers fault dump
// [RULE8] 0100: fall powers channels down, rise up
// [RULE9] 0101: falling edge asserts device protect
// [RULE10] 0111: low level holds device clear
// [RULE11] 1000: falling edge strobes channel load outputs
// [RULE12] 1001: fall stops waveform, rise starts it
// [RULE13] 1010: fall margin low, rise margin high
// [RULE14] 1011: fall resets device, rise releases
// [RULE15] reset function cleared after reset unless stored
// [RULE16] 1100: fall permits memory writes, rise blocks
// [RULE17] 1101: fall unlocks registers, rise locks them
// [RULE18] input bit 0 enables pin input
// [RULE19] protect flag set on protect, cleared by read
// [RULE20] serial-out enable lets pin carry serial data
// [RULE21] two-stage synchroniser, stable-count filter
// [RULE22] all fields reset to zero
package gpf_pkg;
	localparam int CFG_W = 16;
	localparam logic [7:0] CFG_ADDR = 8'h24;
	localparam logic [7:0] FLAG_ADDR = 8'h23;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int FILT_BIT = 15;
	localparam int OUT_BIT = 13;
	localparam int SRC_HI = 12;
	localparam int SRC_LO = 9;
	localparam int MASK_HI = 8;
	localparam int MASK_LO = 5;
	localparam int FUNC_HI = 4;
	localparam int FUNC_LO = 1;
	localparam int IN_BIT = 0;
	localparam logic [15:0] CFG_WMASK = 16'hBFFF;
	// filter settle time and its clock count at 10 MHz
	localparam int FILT_NS = 400;
	localparam int CLK_NS = 100;
	localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] FILT_MAX = 3'(FILT_CYC);
	localparam int NCH = 3;

	typedef enum logic [3:0] {
		GPF_SRC_MEM = 4'h1,
		GPF_SRC_CH2 = 4'h4,
		GPF_SRC_CH0A = 4'h6,
		GPF_SRC_CH0B = 4'h7,
		GPF_SRC_WIN = 4'hB
	} gpf_src_e;

	typedef enum logic [3:0] {
		GPF_FN_SLEEP = 4'h0,
		GPF_FN_DUMP = 4'h2,
		GPF_FN_PWR = 4'h4,
		GPF_FN_PROT = 4'h5,
		GPF_FN_CLEAR = 4'h7,
		GPF_FN_LOAD = 4'h8,
		GPF_FN_WAVE = 4'h9,
		GPF_FN_MARGIN = 4'hA,
		GPF_FN_RESET = 4'hB,
		GPF_FN_MEMWP = 4'hC,
		GPF_FN_LOCK = 4'hD
	} gpf_fn_e;

	// internal status bits that the pin may mirror; no source code selects ch1_busy
	typedef struct packed {
		logic memory_write_busy;
		logic ch0_busy;
		logic ch1_busy;
		logic ch2_busy;
		logic window_compare_result;
	} gpf_status_s;

	// per-channel action outputs, index = channel number
	typedef struct packed {
		logic [2:0] powerdown;
		logic [2:0] load_outputs_strobe;
		logic [2:0] wave_stop;
		logic [2:0] wave_start;
		logic [2:0] margin_low;
		logic [2:0] margin_high;
	} gpf_chan_s;
endpackage : gpf_pkg

// >>> design/gpf_pin_function.sv
// pin function block: config register, pin output mux, input dispatch
// assumes the serial front end gives a register port with one-cycle strobes
`timescale 1ns/100ps
module gpf_pin_function (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic reset_fn_stored,
	input wire logic serial_out_on,
	input wire logic serial_out_data,
	// shared pin
	input wire logic shared_pin_i,
	output logic shared_pin_o,
	output logic shared_pin_oe,
	// status in
	input wire gpf_pkg::gpf_status_s status,
	input wire logic protect_running,
	// global actions
	output logic deep_sleep,
	output logic fault_dump,
	output logic protect_req,
	output logic output_clear,
	output logic device_reset,
	output logic memory_write_allowed,
	output logic map_locked,
	output logic protect_flag,
	// channel actions
	output gpf_pkg::gpf_chan_s chan
);
	logic [15:0] cfg_reg, cfg_next;
	logic sync1_reg, sync2_reg, filt_reg, filt_next, prev_reg;
	logic [2:0] cnt_reg, cnt_next;
	logic sleep_reg, reset_reg, memwp_reg, lock_reg, flag_reg, clear_reg;
	logic dump_reg, prot_reg;
	gpf_pkg::gpf_chan_s chan_reg;

	wire cfg_hit = reg_addr == gpf_pkg::CFG_ADDR;
	wire filt_on = cfg_reg[gpf_pkg::FILT_BIT];
	wire out_on = cfg_reg[gpf_pkg::OUT_BIT];
	wire in_on = cfg_reg[gpf_pkg::IN_BIT];
	wire [3:0] src = cfg_reg[gpf_pkg::SRC_HI:gpf_pkg::SRC_LO];
	wire [3:0] mask = cfg_reg[gpf_pkg::MASK_HI:gpf_pkg::MASK_LO];
	wire [3:0] func = cfg_reg[gpf_pkg::FUNC_HI:gpf_pkg::FUNC_LO];

	// map mask bits onto channel numbers; bit 1 is not wired
	function automatic logic [2:0] ch_sel(input logic [3:0] m);
		ch_sel = {m[0], m[3], m[2]};
	endfunction : ch_sel

	wire [2:0] sel = ch_sel(mask); // [RULE4]

	// reset function does not survive a reset unless stored in memory
	wire [15:0] cfg_rst_val = (reset_fn_stored &&
		func == gpf_pkg::GPF_FN_RESET) ? cfg_reg : gpf_pkg::CFG_RESET;
	always_comb begin
		cfg_next = cfg_reg;
		if (reg_wr && cfg_hit && !lock_reg) begin
			cfg_next = reg_wdata & gpf_pkg::CFG_WMASK;
		end
	end

	// the reset this block raises is looped back via srst by the device
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg_reg <= cfg_rst_val; // [RULE15] [RULE22]
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// input conditioning: two flops, then a stable-count filter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= shared_pin_i; // [RULE21]
			sync2_reg <= sync1_reg;
		end
	end

	always_comb begin
		cnt_next = 3'h0;
		filt_next = filt_reg;
		if (!filt_on) begin
			filt_next = sync2_reg; // [RULE1]
		end else if (sync2_reg != filt_reg) begin
			cnt_next = cnt_reg + 3'h1;
			if (cnt_reg == gpf_pkg::FILT_MAX - 3'h1) begin
				filt_next = sync2_reg; // [RULE1] [RULE21]
				cnt_next = 3'h0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			filt_reg <= 1'b1;
			cnt_reg <= 3'h0;
			prev_reg <= 1'b1;
		end else begin
			filt_reg <= filt_next;
			cnt_reg <= cnt_next;
			prev_reg <= filt_reg;
		end
	end

	// edges only count while input mode is on; a stray level is harmless
	wire fall = in_on && prev_reg && !filt_reg; // [RULE18]
	wire rise = in_on && !prev_reg && filt_reg; // [RULE18]
	function automatic logic is_fn(input logic [3:0] f, input logic [3:0] c);
		is_fn = f == c;
	endfunction : is_fn
	wire f_sleep = is_fn(func, gpf_pkg::GPF_FN_SLEEP); // [RULE5]
	wire f_dump = is_fn(func, gpf_pkg::GPF_FN_DUMP);
	wire f_pwr = is_fn(func, gpf_pkg::GPF_FN_PWR);
	wire f_prot = is_fn(func, gpf_pkg::GPF_FN_PROT);
	wire f_clear = is_fn(func, gpf_pkg::GPF_FN_CLEAR);
	wire f_load = is_fn(func, gpf_pkg::GPF_FN_LOAD);
	wire f_wave = is_fn(func, gpf_pkg::GPF_FN_WAVE);
	wire f_marg = is_fn(func, gpf_pkg::GPF_FN_MARGIN);
	wire f_reset = is_fn(func, gpf_pkg::GPF_FN_RESET);
	wire f_memwp = is_fn(func, gpf_pkg::GPF_FN_MEMWP);
	wire f_lock = is_fn(func, gpf_pkg::GPF_FN_LOCK);
	wire flag_read = reg_rd && reg_addr == gpf_pkg::FLAG_ADDR;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sleep_reg <= 1'b0;
			dump_reg <= 1'b0;
			prot_reg <= 1'b0;
			clear_reg <= 1'b0;
			reset_reg <= 1'b0;
			memwp_reg <= 1'b0;
			lock_reg <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			if (f_sleep && fall) sleep_reg <= 1'b1; // [RULE6]
			else if (f_sleep && rise) sleep_reg <= 1'b0; // [RULE6]
			dump_reg <= f_dump && fall; // [RULE7]
			prot_reg <= f_prot && fall; // [RULE9]
			clear_reg <= in_on && f_clear && !filt_reg; // [RULE10]
			if (f_reset && fall) reset_reg <= 1'b1; // [RULE14]
			else if (f_reset && rise) reset_reg <= 1'b0; // [RULE14]
			if (f_memwp && fall) memwp_reg <= 1'b1; // [RULE16]
			else if (f_memwp && rise) memwp_reg <= 1'b0; // [RULE16]
			if (f_lock && fall) lock_reg <= 1'b0; // [RULE17]
			else if (f_lock && rise) lock_reg <= 1'b1; // [RULE17]
			// set wins over the clearing read
			if ((f_prot && fall) || protect_running) begin
				flag_reg <= 1'b1; // [RULE19]
			end else if (flag_read) begin
				flag_reg <= 1'b0; // [RULE19]
			end
		end
	end

	// per-channel actions, one generate lane per channel
	for (genvar i = 0; i < gpf_pkg::NCH; i++) begin : g_ch
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				chan_reg.powerdown[i] <= 1'b0;
				chan_reg.load_outputs_strobe[i] <= 1'b0;
				chan_reg.wave_stop[i] <= 1'b0;
				chan_reg.wave_start[i] <= 1'b0;
				chan_reg.margin_low[i] <= 1'b0;
				chan_reg.margin_high[i] <= 1'b0;
			end else begin
				if (sel[i] && f_pwr && fall) begin
					chan_reg.powerdown[i] <= 1'b1; // [RULE8]
				end else if (sel[i] && f_pwr && rise) begin
					chan_reg.powerdown[i] <= 1'b0; // [RULE8]
				end
				// sync mode per channel is checked downstream
				chan_reg.load_outputs_strobe[i] <= sel[i] && f_load && fall; // [RULE11]
				chan_reg.wave_stop[i] <= sel[i] && f_wave && fall; // [RULE12]
				chan_reg.wave_start[i] <= sel[i] && f_wave && rise; // [RULE12]
				chan_reg.margin_low[i] <= sel[i] && f_marg && fall; // [RULE13]
				chan_reg.margin_high[i] <= sel[i] && f_marg && rise; // [RULE13]
			end
		end
	end
	assign chan = chan_reg;

	// pin output: serial data has priority when its enable is set
	logic src_bit;
	always_comb begin
		unique case (src)
			gpf_pkg::GPF_SRC_MEM: src_bit = status.memory_write_busy; // [RULE3]
			gpf_pkg::GPF_SRC_CH2: src_bit = status.ch2_busy;
			gpf_pkg::GPF_SRC_CH0A, gpf_pkg::GPF_SRC_CH0B: src_bit = status.ch0_busy;
			gpf_pkg::GPF_SRC_WIN: src_bit = status.window_compare_result;
			default: src_bit = 1'b0;
		endcase
	end
	logic pin_o_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) pin_o_reg <= 1'b0;
		else pin_o_reg <= serial_out_on ? serial_out_data : src_bit; // [RULE20]
	end
	assign shared_pin_o = pin_o_reg;
	assign shared_pin_oe = serial_out_on || out_on; // [RULE2] [RULE20]

	assign reg_rdata = cfg_hit ? cfg_reg : 16'h0000;
	assign deep_sleep = sleep_reg;
	assign fault_dump = dump_reg;
	assign protect_req = prot_reg;
	assign output_clear = clear_reg;
	assign device_reset = reset_reg;
	assign memory_write_allowed = memwp_reg;
	assign map_locked = lock_reg;
	assign protect_flag = flag_reg;

	property p_cfg_zero;
		@(posedge ref_clk) $rose(srst) |=> (cfg_reg == 16'h0000 ||
			cfg_reg[gpf_pkg::FUNC_HI:gpf_pkg::FUNC_LO] == 4'hB);
	endproperty
	a_cfg_zero: assert property (p_cfg_zero) else $error("cfg not cleared"); // [RULE22]
	property p_oe;
		@(posedge ref_clk) disable iff (srst)
			(!serial_out_on && !out_on) |-> !shared_pin_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven while off"); // [RULE2]
	property p_no_in;
		@(posedge ref_clk) disable iff (srst) !in_on |=> !dump_reg && !prot_reg;
	endproperty
	a_no_in: assert property (p_no_in) else $error("action with input off"); // [RULE18]
	property p_sleep;
		@(posedge ref_clk) disable iff (srst) (f_sleep && fall) |=> deep_sleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep missed"); // [RULE6]
	property p_dump;
		@(posedge ref_clk) disable iff (srst) fault_dump |-> $past(f_dump);
	endproperty
	a_dump: assert property (p_dump) else $error("stray dump"); // [RULE7]
	property p_flag;
		@(posedge ref_clk) disable iff (srst) protect_req |-> protect_flag;
	endproperty
	a_flag: assert property (p_flag) else $error("protect flag lost"); // [RULE19]
	property p_lock;
		@(posedge ref_clk) disable iff (srst)
			(lock_reg && reg_wr && cfg_hit) |=> $stable(cfg_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("write while locked"); // [RULE17]
	property p_clear;
		@(posedge ref_clk) disable iff (srst)
			(in_on && f_clear && !filt_reg) ##1 (in_on && f_clear) |-> output_clear;
	endproperty
	a_clear: assert property (p_clear) else $error("clear not held"); // [RULE10]

	property p_filt_off;
		@(posedge ref_clk) disable iff (srst)
			!filt_on |=> filt_reg == $past(sync2_reg);
	endproperty
	a_filt_off: assert property (p_filt_off) else $error("bypass late"); // [RULE1]

	property p_filt_cnt;
		@(posedge ref_clk) disable iff (srst) cnt_reg < gpf_pkg::FILT_MAX;
	endproperty
	a_filt_cnt: assert property (p_filt_cnt) else $error("count overrun"); // [RULE21]

	property p_filt_chg;
		@(posedge ref_clk) disable iff (srst)
			($past(filt_on) && filt_reg != $past(filt_reg)) |->
			$past(cnt_reg) == gpf_pkg::FILT_MAX - 3'h1;
	endproperty
	a_filt_chg: assert property (p_filt_chg) else $error("glitch passed"); // [RULE1]

	property p_sync;
		@(posedge ref_clk) disable iff (srst) sync2_reg == $past(sync1_reg);
	endproperty
	a_sync: assert property (p_sync) else $error("sync stage skipped"); // [RULE21]

	// mirrored status lags its source by the output flop
	property p_src_win;
		@(posedge ref_clk) disable iff (srst)
			(!serial_out_on && src == gpf_pkg::GPF_SRC_WIN) |=>
			shared_pin_o == $past(status.window_compare_result);
	endproperty
	a_src_win: assert property (p_src_win) else $error("window not shown"); // [RULE3]

	property p_src_mem;
		@(posedge ref_clk) disable iff (srst)
			(!serial_out_on && src == gpf_pkg::GPF_SRC_MEM) |=>
			shared_pin_o == $past(status.memory_write_busy);
	endproperty
	a_src_mem: assert property (p_src_mem) else $error("busy not shown"); // [RULE3]

	property p_src_na;
		@(posedge ref_clk) disable iff (srst)
			(!serial_out_on && src == 4'h2) |=> !shared_pin_o;
	endproperty
	a_src_na: assert property (p_src_na) else $error("unlisted source"); // [RULE3]

	property p_sdo;
		@(posedge ref_clk) disable iff (srst)
			serial_out_on |=> shared_pin_o == $past(serial_out_data);
	endproperty
	a_sdo: assert property (p_sdo) else $error("serial data lost"); // [RULE20]

	property p_oe_on;
		@(posedge ref_clk) disable iff (srst) out_on |-> shared_pin_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not driven"); // [RULE2]

	property p_load;
		@(posedge ref_clk) disable iff (srst)
			chan.load_outputs_strobe != 3'h0 |-> $past(f_load && fall);
	endproperty
	a_load: assert property (p_load) else $error("stray load"); // [RULE11]

	property p_sel;
		@(posedge ref_clk) disable iff (srst)
			(chan.wave_stop & ~$past(sel)) == 3'h0;
	endproperty
	a_sel: assert property (p_sel) else $error("unselected channel"); // [RULE4]

	property p_pdn;
		@(posedge ref_clk) disable iff (srst)
			(f_pwr && fall && sel[0]) |=> chan.powerdown[0];
	endproperty
	a_pdn: assert property (p_pdn) else $error("powerdown missed"); // [RULE8]

	property p_prot;
		@(posedge ref_clk) disable iff (srst) (f_prot && fall) |=> protect_req;
	endproperty
	a_prot: assert property (p_prot) else $error("protect missed"); // [RULE9]

	property p_wave;
		@(posedge ref_clk) disable iff (srst)
			(f_wave && rise) |=> chan.wave_start == $past(sel);
	endproperty
	a_wave: assert property (p_wave) else $error("start missed"); // [RULE12]

	property p_marg;
		@(posedge ref_clk) disable iff (srst)
			(f_marg && fall) |=> chan.margin_low == $past(sel);
	endproperty
	a_marg: assert property (p_marg) else $error("margin low missed"); // [RULE13]

	property p_rst;
		@(posedge ref_clk) disable iff (srst) (f_reset && fall) |=> device_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("reset missed"); // [RULE14]

	property p_memwp;
		@(posedge ref_clk) disable iff (srst)
			(f_memwp && rise) |=> !memory_write_allowed;
	endproperty
	a_memwp: assert property (p_memwp) else $error("memory not blocked"); // [RULE16]

	property p_lock_set;
		@(posedge ref_clk) disable iff (srst) (f_lock && rise) |=> map_locked;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("map not locked"); // [RULE17]
endmodule : gpf_pin_function

// >>> dv/gpf_pin_driver.sv
// partner: outside logic that drives the shared pin
// assumes it is the only driver while the device leaves the pin
`timescale 1ns/100ps
module gpf_pin_driver (
	// clock
	input wire logic ref_clk,
	// pin as the device sees it
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic pin_i
);
	logic lvl = 1'b1;
	// device wins while it drives; idle high so no false fall
	assign pin_i = pin_oe ? pin_o : lvl;
	// levels change just after an edge and are held
	task automatic set_level(input logic v);
		@(posedge ref_clk);
		lvl <= v;
	endtask : set_level
	// reset use wants a short pulse, never a held low
	task automatic pulse_low(input int n);
		set_level(1'b0);
		repeat (n) @(posedge ref_clk);
		lvl <= 1'b1;
	endtask : pulse_low
endmodule : gpf_pin_driver

// >>> dv/gpf_pin_function_bench.sv
// bench: register and pin sequences for the pin function block
// assumes the driver model owns the pin while the device is off it
`timescale 1ns/100ps
module gpf_pin_function_bench;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic stored = 1'b0;
	logic sd_on = 1'b0;
	logic sd_dat = 1'b0;
	logic prot_run = 1'b0;
	logic pin_i, pin_o, pin_oe, sleep, dump, prot, clr_o;
	logic dev_rst, mem_ok, locked, pflag;
	gpf_pkg::gpf_status_s status = '0;
	gpf_pkg::gpf_chan_s chan;
	gpf_pkg::gpf_chan_s seen;
	int n_dump, n_prot, n_rst, bad_count, checks;
	logic [3:0] src_t [5] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'hB};
	logic [4:0] st_t [5] = '{5'h10, 5'h02, 5'h08, 5'h08, 5'h01};
	logic [15:0] k;
	always #50 ref_clk = ~ref_clk;
	gpf_pin_function dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reset_fn_stored(stored),
		.serial_out_on(sd_on), .serial_out_data(sd_dat),
		.shared_pin_i(pin_i), .shared_pin_o(pin_o), .shared_pin_oe(pin_oe),
		.status(status), .protect_running(prot_run), .deep_sleep(sleep),
		.fault_dump(dump), .protect_req(prot), .output_clear(clr_o),
		.device_reset(dev_rst), .memory_write_allowed(mem_ok),
		.map_locked(locked), .protect_flag(pflag), .chan(chan));
	gpf_pin_driver drv (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_i(pin_i));
	// one-cycle pulses are caught here so no check can miss them
	always @(posedge ref_clk) begin
		seen <= seen | chan;
		n_dump <= n_dump + int'(dump === 1'b1);
		n_prot <= n_prot + int'(prot === 1'b1);
		n_rst <= n_rst | int'(dev_rst === 1'b1);
	end
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(negedge ref_clk);
		chk("rdata", e, reg_rdata);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd
	// long enough for sync, filter and output stages
	task automatic pin(input logic v);
		drv.set_level(v);
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : pin
	task automatic go(input logic [3:0] fn, input logic f);
		wr(8'h24, {f, 2'b00, 4'h0, 4'hB, fn, 1'b1});
		@(negedge ref_clk);
		seen = '0;
		n_dump = 0;
		n_prot = 0;
		n_rst = 0;
	endtask : go
	task automatic sreset;
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
	endtask : sreset
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		sreset();
		rd(8'h24, 16'h0000);
		rd(8'h10, 16'h0000);
		go(4'h2, 1'b0);
		wr(8'h24, 16'h0000);
		pin(1'b0);
		pin(1'b1);
		chk("idle", 16'h0000, {sleep, pin_oe, n_dump[13:0]});
		wr(8'h24, 16'hFFFF);
		rd(8'h24, 16'hBFFF);
		pin(1'b0);
		pin(1'b1);
		chk("invalid", 16'h0000, 16'(|seen) + 16'(n_dump + n_prot));
		$display("test reset and access done");
		for (int i = 0; i < 5; i++) begin
			wr(8'h24, {3'b001, src_t[i], 9'h000});
			status <= st_t[i];
			pin(1'b1);
			chk("out", 16'h0003, {pin_oe, pin_o});
			@(posedge ref_clk);
			status <= ~st_t[i];
			pin(1'b1);
			chk("out", 16'h0002, {pin_oe, pin_o});
		end
		wr(8'h24, 16'h0200);
		pin(1'b1);
		chk("oe", 16'h0000, pin_oe);
		$display("test output done");
		go(4'h0, 1'b0);
		pin(1'b0);
		chk("sleep", 16'h0001, sleep);
		pin(1'b1);
		chk("sleep", 16'h0000, sleep);
		go(4'h4, 1'b0);
		pin(1'b0);
		chk("pdn", 16'h0006, chan.powerdown);
		pin(1'b1);
		chk("pdn", 16'h0000, chan.powerdown);
		go(4'h7, 1'b0);
		pin(1'b0);
		chk("clear", 16'h0001, clr_o);
		pin(1'b1);
		chk("clear", 16'h0000, clr_o);
		go(4'hC, 1'b0);
		pin(1'b0);
		chk("nvm", 16'h0001, mem_ok);
		pin(1'b1);
		chk("nvm", 16'h0000, mem_ok);
		go(4'h9, 1'b0);
		pin(1'b0);
		chk("wave", 16'h0030, {seen.wave_stop, seen.wave_start});
		pin(1'b1);
		chk("wave", 16'h0036, {seen.wave_stop, seen.wave_start});
		go(4'hA, 1'b0);
		pin(1'b0);
		chk("mrg", 16'h0030, {seen.margin_low, seen.margin_high});
		pin(1'b1);
		chk("mrg", 16'h0036, {seen.margin_low, seen.margin_high});
		go(4'h8, 1'b0);
		pin(1'b0);
		pin(1'b1);
		chk("load", 16'h0006, seen.load_outputs_strobe);
		go(4'h5, 1'b0);
		pin(1'b0);
		pin(1'b1);
		chk("prot", 16'h0001, n_prot[15:0]);
		go(4'h2, 1'b1);
		drv.pulse_low(2);
		pin(1'b1);
		chk("glitch", 16'h0000, n_dump[15:0]);
		pin(1'b0);
		pin(1'b1);
		chk("dump", 16'h0001, n_dump[15:0]);
		go(4'h2, 1'b0);
		drv.pulse_low(2);
		pin(1'b1);
		chk("nofilt", 16'h0001, n_dump[15:0]);
		wr(8'h24, 16'h0004);
		pin(1'b0);
		pin(1'b1);
		chk("inoff", 16'h0001, n_dump[15:0]);
		$display("test input functions done");
		go(4'hB, 1'b0);
		drv.pulse_low(3);
		pin(1'b1);
		chk("rst", 16'h0001, {dev_rst, n_rst[14:0]});
		k = 16'h0177;
		stored <= 1'b1;
		sreset();
		rd(8'h24, k);
		stored <= 1'b0;
		sreset();
		rd(8'h24, 16'h0000);
		go(4'hD, 1'b0);
		pin(1'b0);
		pin(1'b1);
		chk("lock", 16'h0001, locked);
		wr(8'h24, 16'h0000);
		rd(8'h24, 16'h017B);
		pin(1'b0);
		chk("lock", 16'h0000, locked);
		wr(8'h24, 16'h0000);
		rd(8'h24, 16'h0000);
		$display("test reset and lock done");
		@(posedge ref_clk);
		prot_run <= 1'b1;
		@(posedge ref_clk);
		prot_run <= 1'b0;
		pin(1'b1);
		chk("pflag", 16'h0001, pflag);
		rd(8'h23, 16'h0000);
		pin(1'b1);
		chk("pflag", 16'h0000, pflag);
		@(posedge ref_clk);
		sd_on <= 1'b1;
		sd_dat <= 1'b1;
		pin(1'b1);
		chk("sdo", 16'h0003, {pin_oe, pin_o});
		@(posedge ref_clk);
		sd_dat <= 1'b0;
		pin(1'b1);
		chk("sdo", 16'h0002, {pin_oe, pin_o});
		$display("test flag and serial out done");
		give_verdict();
	end
endmodule : gpf_pin_function_bench
